// ### wiper_defines.svh
// Constants for the pushbutton wiper stepper
`ifndef WIPER_DEFINES_SVH
`define WIPER_DEFINES_SVH

`define CLK_HZ 25000000
`define MS_PER_S 1000
`define US_PER_S 1000000
`define CONTACT_MIN_MS 1
`define STEP_MIN_US 1
`define HOLD_MS 1000
`define REPEAT_MS 100
`define IDLE_MS 1000
`define SAVE_DELAY_MS 2000
`define TMR_W 12
`define FLT_W 24
`define POS_W 6
`define POS_MIN 6'h00
`define POS_MAX 6'h3F
`define POS_ONE 6'h01
`define SAVE_BIT 3
`define CH_UP 0
`define CH_DOWN 1
`define CH_STEP 2
`define CH_NUM 3

`endif

// ### wiper_pkg.sv
// Types shared by the pushbutton wiper stepper
package wiper_pkg;
   typedef logic [5:0] pos_t;
   typedef enum logic {MODE_DUAL, MODE_SINGLE} mode_t;
endpackage

// ### pushbutton_wiper_stepper.sv
// Control logic of a 64-position pushbutton-stepped rheostat wiper
//
// Contract
// - Control inputs active low, high inactive
// - 64 taps, one tap per step
// - Pulse starts at high-to-low transition
// - Pulse over 1 ms moves one position
// - Under 1 ms high merges pulses
// - Held past 1 s: step every 100 ms
// - Single mode: up contact both ways
// - Floating down contact selects dual mode
// - First direction opposes previous activity
// - Reverse after 1 s idle or end
// - Step input uses single-mode direction rules
// - Step input works in either mode
// - Step input accepts faster pulses
// - Dual mode: up/down contacts, no wait
// - Dual mode saturates at range ends
// - Contact inputs debounced internally
// - Step input pulse of 1 us recognised
// - Restore saved position at power-up
// - Save two seconds after change; first always
// - Later saves only when bit 3 changes
`timescale 1ns/100ps
`include "wiper_defines.svh"

module pushbutton_wiper_stepper #(
   parameter int unsigned MS_CYC = `CLK_HZ / `MS_PER_S,
   parameter int unsigned CONTACT_MIN_CYC =
      (`CONTACT_MIN_MS * `CLK_HZ + `MS_PER_S - 1) / `MS_PER_S
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic up_contact_n_in,
   input wire logic down_contact_n_in,
   input wire logic step_n_in,
   input wire logic single_strap_in,
   input wire wiper_pkg::pos_t nv_pos_in,
   output logic [`POS_W-1:0] wiper_pos_out,
   output logic single_mode_out,
   output logic nv_save_out,
   output logic [`POS_W-1:0] nv_pos_out
);

   localparam int unsigned STEP_MIN_CYC =
      (`STEP_MIN_US * `CLK_HZ + `US_PER_S - 1) / `US_PER_S;

   // ==========================================================
   // Millisecond time base
   // ==========================================================
   // Free-running tick shared by the hold, idle and save timers
   logic [`FLT_W-1:0] pre_q;
   logic ms_tick;

   assign ms_tick = (pre_q == `FLT_W'(MS_CYC - 1));

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         pre_q <= '0;
      end else if (ms_tick) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + `FLT_W'(1);
      end
   end

   // ==========================================================
   // Power-up: position restore and mode strap
   // ==========================================================
   logic init_q;
   wiper_pkg::mode_t mode_q;

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         init_q <= 1'b0;
         mode_q <= wiper_pkg::MODE_DUAL;
      end else if (!init_q) begin
         init_q <= 1'b1;
         // Strap high means down contact tied to supply
         mode_q <= single_strap_in ? wiper_pkg::MODE_SINGLE
                                   : wiper_pkg::MODE_DUAL;
      end
   end

   // Mode is fixed until the next reset
   assign single_mode_out = (mode_q == wiper_pkg::MODE_SINGLE);

   // ==========================================================
   // Input channels: sync, pulse filter, hold repeat
   // ==========================================================
   logic [`CH_NUM-1:0] raw_n;
   logic [`CH_NUM-1:0] act;
   logic [`CH_NUM-1:0] ev;

   assign raw_n = {step_n_in, down_contact_n_in, up_contact_n_in};

   genvar g;
   for (g = 0; g < `CH_NUM; g++) begin : g_ch
      localparam int unsigned MIN_CYC =
         (g == `CH_STEP) ? STEP_MIN_CYC : CONTACT_MIN_CYC;
      logic s1_q;
      logic s2_q;
      logic act_q;
      logic act_d1_q;
      logic [`FLT_W-1:0] flt_q;
      logic [`TMR_W-1:0] hold_q;
      logic rpt;

      always_ff @(posedge mclk_in) begin
         if (!nrst_in) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
         end else begin
            s1_q <= raw_n[g];
            s2_q <= s1_q;
         end
      end

      // Level must hold MIN_CYC before it is taken; a short
      // high gap never releases, so pulses merge
      always_ff @(posedge mclk_in) begin
         if (!nrst_in) begin
            act_q <= 1'b0;
            flt_q <= '0;
         end else if (!s2_q == act_q) begin
            flt_q <= '0;
         end else if (flt_q == `FLT_W'(MIN_CYC - 1)) begin
            act_q <= !s2_q;
            flt_q <= '0;
         end else begin
            flt_q <= flt_q + `FLT_W'(1);
         end
      end

      always_ff @(posedge mclk_in) begin
         if (!nrst_in) begin
            act_d1_q <= 1'b0;
         end else begin
            act_d1_q <= act_q;
         end
      end

      // Hold timer: 1 s to first repeat, then every 100 ms
      assign rpt = ms_tick && (hold_q == `TMR_W'(`HOLD_MS - 1));

      always_ff @(posedge mclk_in) begin
         if (!nrst_in || !act_q) begin
            hold_q <= '0;
         end else if (rpt) begin
            hold_q <= `TMR_W'(`HOLD_MS - `REPEAT_MS);
         end else if (ms_tick) begin
            hold_q <= hold_q + `TMR_W'(1);
         end
      end

      // Event on recognition and on each hold repeat
      assign act[g] = act_q;
      assign ev[g] = (act_q && !act_d1_q) || (act_q && rpt);
   end

   // ==========================================================
   // Direction tracking for the shared-button rules
   // ==========================================================
   logic [`POS_W-1:0] wiper_q;
   logic [`POS_W-1:0] wiper_d;
   logic last_up_q;
   logic [`TMR_W-1:0] idle_q;
   logic idle;
   logic share_act;
   logic share_ev;
   logic auto_up;
   logic mv_en;
   logic mv_up;

   assign share_act = (act[`CH_UP] && single_mode_out) ||
                      act[`CH_STEP];
   assign share_ev = (ev[`CH_UP] && single_mode_out) ||
                     ev[`CH_STEP];
   assign idle = (idle_q > `TMR_W'(`IDLE_MS));

   // Idle counter saturates just past the limit
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         idle_q <= `TMR_W'(`IDLE_MS + 1);
      end else if (share_act) begin
         idle_q <= '0;
      end else if (ms_tick && !idle) begin
         idle_q <= idle_q + `TMR_W'(1);
      end
   end

   // Direction flips after idle, reverses at the ends
   always_comb begin
      auto_up = idle ? !last_up_q : last_up_q;
      if (auto_up && wiper_q == `POS_MAX) begin
         auto_up = 1'b0;
      end else if (!auto_up && wiper_q == `POS_MIN) begin
         auto_up = 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         last_up_q <= 1'b0;
      end else if (init_q && share_ev && !mv_up_dual()) begin
         last_up_q <= auto_up;
      end
   end

   // Dual-mode contacts take priority over the shared channel
   function automatic logic mv_up_dual();
      mv_up_dual = !single_mode_out && (ev[`CH_UP] || ev[`CH_DOWN]);
   endfunction

   // ==========================================================
   // Wiper position
   // ==========================================================
   always_comb begin
      mv_en = 1'b0;
      mv_up = 1'b0;
      if (init_q) begin
         if (!single_mode_out && ev[`CH_UP]) begin
            mv_en = 1'b1;
            mv_up = 1'b1;
         end else if (!single_mode_out && ev[`CH_DOWN]) begin
            mv_en = 1'b1;
            mv_up = 1'b0;
         end else if (share_ev) begin
            mv_en = 1'b1;
            mv_up = auto_up;
         end
      end
      wiper_d = wiper_q;
      if (mv_en && mv_up && wiper_q != `POS_MAX) begin
         wiper_d = wiper_q + `POS_ONE;
      end else if (mv_en && !mv_up && wiper_q != `POS_MIN) begin
         wiper_d = wiper_q - `POS_ONE;
      end
   end

   // Stored position loaded on first edge after reset
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         wiper_q <= `POS_MIN;
      end else if (!init_q) begin
         wiper_q <= nv_pos_in;
      end else begin
         wiper_q <= wiper_d;
      end
   end

   assign wiper_pos_out = wiper_q;

   // ==========================================================
   // Nonvolatile save scheduling
   // ==========================================================
   logic saved_once_q;
   logic pending_q;
   logic [`TMR_W-1:0] save_q;
   logic changed;
   logic trig;
   logic save_now;

   // Change seen one cycle before it lands
   assign changed = init_q && (wiper_d != wiper_q);
   assign trig = changed && (!saved_once_q ||
      wiper_d[`SAVE_BIT] != wiper_q[`SAVE_BIT]);
   // Save only once the position has settled
   assign save_now = pending_q && !changed && ms_tick &&
      (save_q == `TMR_W'(`SAVE_DELAY_MS - 1));

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         pending_q <= 1'b0;
         save_q <= '0;
      end else if (trig || (pending_q && changed)) begin
         // Each further move restarts the delay
         pending_q <= 1'b1;
         save_q <= '0;
      end else if (save_now) begin
         pending_q <= 1'b0;
      end else if (pending_q && ms_tick) begin
         save_q <= save_q + `TMR_W'(1);
      end
   end

   // Stored value and strobe leave together
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         saved_once_q <= 1'b0;
         nv_save_out <= 1'b0;
         nv_pos_out <= `POS_MIN;
      end else begin
         nv_save_out <= save_now;
         if (save_now) begin
            saved_once_q <= 1'b1;
            nv_pos_out <= wiper_q;
         end
      end
   end

endmodule

// ### wiper_monitor.sv
// Port checker for the wiper stepper
`timescale 1ns/100ps
module wiper_monitor #(
   parameter int unsigned MS_CYC = 25000,
   parameter int unsigned CONTACT_MIN_CYC = 25000
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic up_contact_n_in,
   input wire logic down_contact_n_in,
   input wire logic step_n_in,
   input wire logic single_strap_in,
   input wire wiper_pkg::pos_t nv_pos_in,
   input wire logic [5:0] wiper_pos_out,
   input wire logic single_mode_out,
   input wire logic nv_save_out,
   input wire logic [5:0] nv_pos_out
);
   logic [1:0] age_q;
   logic [31:0] quiet_q;
   logic any_low;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   assign any_low = !up_contact_n_in || !down_contact_n_in || !step_n_in;
   // Edges since reset release
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         age_q <= 2'h0;
      end else if (age_q != 2'h3) begin
         age_q <= age_q + 2'h1;
      end
   end
   // Cycles since the wiper last moved
   always_ff @(posedge mclk_in) begin
      if (!nrst_in || $changed(wiper_pos_out)) begin
         quiet_q <= 32'h0;
      end else if (quiet_q != 32'hFFFFFFFF) begin
         quiet_q <= quiet_q + 32'h1;
      end
   end
   sequence s_moved;
      age_q >= 2'h2 && $changed(wiper_pos_out);
   endsequence
   sequence s_one_tap;
      (wiper_pos_out == $past(wiper_pos_out) + 6'h01
         && $past(wiper_pos_out) != 6'h3F)
      || (wiper_pos_out == $past(wiper_pos_out) - 6'h01
         && $past(wiper_pos_out) != 6'h00);
   endsequence
   a_one_tap: assert property (s_moved |-> s_one_tap)
      else $error("wiper jumped or wrapped");
   a_move_cause: assert property (s_moved |-> $past(any_low, 6))
      else $error("wiper moved with no input low");
   a_nv_restore: assert property (age_q == 2'h1 |->
      wiper_pos_out == $past(nv_pos_in))
      else $error("stored position not restored");
   a_mode_strap: assert property (age_q == 2'h1 |->
      single_mode_out == $past(single_strap_in))
      else $error("mode not taken from strap");
   a_mode_kept: assert property (age_q >= 2'h2 |->
      $stable(single_mode_out))
      else $error("mode changed after power-up");
   a_save_pulse: assert property (nv_save_out |=> !nv_save_out)
      else $error("save pulse too long");
   a_save_value: assert property (nv_save_out |->
      nv_pos_out == wiper_pos_out)
      else $error("saved value differs from wiper");
   a_save_delay: assert property (nv_save_out |->
      quiet_q >= 1998 * MS_CYC)
      else $error("save too soon after a move");
endmodule

bind pushbutton_wiper_stepper wiper_monitor #(.MS_CYC(MS_CYC),
   .CONTACT_MIN_CYC(CONTACT_MIN_CYC)) mon (.mclk_in(mclk_in),
   .nrst_in(nrst_in), .up_contact_n_in(up_contact_n_in),
   .down_contact_n_in(down_contact_n_in), .step_n_in(step_n_in),
   .single_strap_in(single_strap_in), .nv_pos_in(nv_pos_in),
   .wiper_pos_out(wiper_pos_out), .single_mode_out(single_mode_out),
   .nv_save_out(nv_save_out), .nv_pos_out(nv_pos_out));

// ### button_model.sv
// Pushbuttons and processor driving the control inputs
`timescale 1ns/100ps
module button_model (
   input wire logic mclk_in,
   output logic up_n_out,
   output logic down_n_out,
   output logic step_n_out,
   output logic strap_out
);
   initial begin
      up_n_out = 1'b1;
      down_n_out = 1'b1;
      step_n_out = 1'b1;
      strap_out = 1'b0;
   end
   task automatic set_strap(input logic tied);
      strap_out <= tied;
   endtask
   // Hold one input low, then release it high
   task automatic press(input int ch, input int low, input int high);
      @(posedge mclk_in);
      if (ch == 0) begin
         up_n_out <= 1'b0;
      end else if (ch == 1) begin
         down_n_out <= 1'b0;
      end else begin
         step_n_out <= 1'b0;
      end
      repeat (low) @(posedge mclk_in);
      up_n_out <= 1'b1;
      down_n_out <= 1'b1;
      step_n_out <= 1'b1;
      repeat (high) @(posedge mclk_in);
   endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the wiper stepper
`timescale 1ns/100ps
module tb_top;
   logic mclk_in = 1'b0;
   logic nrst_in = 1'b0;
   wiper_pkg::pos_t nv_pos_in = 6'h3E;
   logic up_n, down_n, step_n, strap, single_mode_out, nv_save_out;
   logic [5:0] wiper_pos_out, nv_pos_out;
   int fails = 0;
   int n_tests = 0;
   always #20 mclk_in = ~mclk_in;
   button_model pb (.mclk_in(mclk_in), .up_n_out(up_n),
      .down_n_out(down_n), .step_n_out(step_n), .strap_out(strap));
   pushbutton_wiper_stepper #(.MS_CYC(20), .CONTACT_MIN_CYC(20)) uut (
      .mclk_in(mclk_in), .nrst_in(nrst_in), .up_contact_n_in(up_n),
      .down_contact_n_in(down_n), .step_n_in(step_n),
      .single_strap_in(strap), .nv_pos_in(nv_pos_in),
      .wiper_pos_out(wiper_pos_out), .single_mode_out(single_mode_out),
      .nv_save_out(nv_save_out), .nv_pos_out(nv_pos_out));
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic do_reset(input logic tied, input logic [5:0] nv);
      @(posedge mclk_in);
      pb.set_strap(tied);
      nv_pos_in <= nv;
      nrst_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
   endtask
   task automatic t_dual;
      chk(wiper_pos_out, 6'h3E);
      pb.press(0, 100, 100);
      chk(wiper_pos_out, 6'h3F);
      pb.press(0, 100, 100);
      chk(wiper_pos_out, 6'h3F);
      pb.press(1, 100, 100);
      chk(wiper_pos_out, 6'h3E);
      pb.press(1, 10, 100);
      chk(wiper_pos_out, 6'h3E);
      pb.press(1, 60, 5);
      pb.press(1, 60, 100);
      chk(wiper_pos_out, 6'h3D);
   endtask
   task automatic t_step;
      pb.press(2, 30, 30);
      pb.press(2, 30, 30);
      chk(wiper_pos_out, 6'h3F);
      pb.press(2, 30, 100);
      chk(wiper_pos_out, 6'h3E);
   endtask
   task automatic t_save;
      for (int i = 0; i < 45000; i++) begin
         @(posedge mclk_in);
         #1;
         if (nv_save_out === 1'b1) break;
      end
      chk({5'h00, nv_save_out}, 6'h01);
      chk(nv_pos_out, 6'h3E);
   endtask
   task automatic t_single;
      do_reset(1'b1, 6'h10);
      chk({5'h00, single_mode_out}, 6'h01);
      pb.press(1, 100, 100);
      chk(wiper_pos_out, 6'h10);
      pb.press(0, 100, 100);
      chk(wiper_pos_out, 6'h11);
      pb.press(0, 100, 100);
      chk(wiper_pos_out, 6'h12);
      pb.press(0, 23000, 100);
      chk(wiper_pos_out, 6'h15);
      repeat (21000) @(posedge mclk_in);
      pb.press(0, 100, 100);
      chk(wiper_pos_out, 6'h14);
   endtask
   initial begin
      do_reset(1'b0, 6'h3E);
      t_dual();
      t_step();
      t_save();
      t_single();
      give_verdict();
   end
   initial begin
      repeat (120000) @(posedge mclk_in);
      fails++;
      give_verdict();
   end
endmodule
